/* hpe_detector.v */
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Function
// - Clearing the enable bit forces the whole status register to zero.
// - Status bit 3 is read-only, set when queue holds events, cleared by reading queue.
// - Status bit 2 sets on a qualified rising event; software write clears it.
// - Status bit 1 sets on a qualified falling event; software write clears it.
// - Write-clear status bits latch one-cycle pulses and stay low after clearing.
// - Queue, rising and falling status bits only mean something in input mode.
// - Status bit 0 sets on a short pulse (input) or on generation done (output).
// - Enable register holds one enable per status bit; bits 7:4 read zero.
// - Queue holds four two-bit entries, entry 0 low; first event goes to entry 0.
// - A pointer tracks the next entry to fill; each stored event advances it by one.
// - Events only go into empty entries; after entry 3 wrap to entry 0.
// - Entry codes: 00 empty, 01 rising, 10 falling, 11 short pulse.
// - Queue reads zero when the function is disabled or the line is an output.
// - With the next entry occupied, further events are discarded until freed.
// - Low periods shorter than min setting times 50 us plus 100 us are no pulse.
// - Low periods longer than max setting times 50 us plus 100 us are no pulse.
// - Rising event after line stays high for high-detect setting times 50 us plus 100 us.
// - Control bit 0 enables the line function; bit 1 selects output direction.
// - Any status bit both set and enabled raises the summary interrupt.
// - Falling event after line stays low for low-detect setting times 50 us plus 100 us.
// - A valid short pulse leaves the tracked line state high.
`include "hpe_defs.vh"

module hpe_detector
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [15:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   input  wire        hot_plug_line,
   input  wire        pulse_gen_done,
   output wire        line_summary_interrupt
);

   localparam ST_LOW  = 2'b01;
   localparam ST_HIGH = 2'b10;
   localparam [16:0] OFFSET_TICKS = `HPE_OFFSET_TICKS;
   localparam [11:0] TICK_LAST    = `HPE_TICK_CYC - 1;

   // Threshold in ticks: setting plus the fixed offset
   function [16:0] ticks_of;
      input [15:0] setting;
      begin
         ticks_of = {1'b0, setting} + OFFSET_TICKS;
      end
   endfunction

   // Address match against a register index
   function hit;
      input [15:0] addr;
      input [11:0] idx;
      begin
         hit = (addr == {2'b00, idx, 2'b00});
      end
   endfunction

   reg  [1:0]  line_control;
   reg  [3:0]  hot_plug_event_status;
   reg  [3:0]  hot_plug_event_irq_enable;
   reg  [7:0]  hot_plug_event_queue;
   reg  [7:0]  short_pulse_min_time;
   reg  [7:0]  short_pulse_max_time;
   reg  [15:0] rising_detect_time;
   reg  [15:0] falling_detect_time;
   reg  [1:0]  wr_ptr;
   reg         sync1;
   reg         sync2;
   reg         sync3;
   reg         line_level;
   reg  [11:0] prescale;
   reg  [16:0] duration;
   reg  [1:0]  state;
   reg         ev_valid;
   reg  [1:0]  ev_code;
   reg  [1:0]  next_state;
   reg  [31:0] next_rdata;
   reg         next_err;
   reg  [7:0]  next_queue;
   integer     i;

   wire line_enabled = line_control[`HPE_CTL_ENABLE_BIT];
   wire line_output  = line_control[`HPE_CTL_OUTPUT_BIT];
   wire input_active = line_enabled & ~line_output;
   wire setup_phase  = psel & ~penable;
   wire wr_access    = psel & penable & pwrite;
   wire rd_access    = psel & penable & ~pwrite;
   wire wr_low       = wr_access & pstrb[0];
   wire wr_high      = wr_access & pstrb[1];
   wire tick         = (prescale == TICK_LAST);
   wire level_change = (sync2 == sync3) & (sync3 != line_level);
   wire queue_read   = rd_access & hit(paddr, `HPE_IDX_EVENT_QUEUE);
   wire [1:0] slot   = hot_plug_event_queue[{wr_ptr, 1'b0} +: 2];
   wire store_event  = ev_valid & (slot == `HPE_ENTRY_EMPTY);

   assign pready = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Line synchroniser and filtered level
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1      <= 1'b0;
         sync2      <= 1'b0;
         sync3      <= 1'b0;
         line_level <= 1'b0;
      end
      else
      begin
         sync1 <= hot_plug_line;
         sync2 <= sync1;
         sync3 <= sync2;
         if (level_change)
            line_level <= sync3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // 50 us timebase, restarted on every level change so periods are exact
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prescale <= 12'h000;
         duration <= 17'h00000;
      end
      else if (level_change || !input_active)
      begin
         prescale <= 12'h000;
         duration <= 17'h00000;
      end
      else if (tick)
      begin
         prescale <= 12'h000;
         if (duration != 17'h1FFFF)
            duration <= duration + 17'h00001;
      end
      else
         prescale <= prescale + 12'h001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event detection
   always @*
   begin
      next_state = state;
      ev_valid   = 1'b0;
      ev_code    = `HPE_ENTRY_EMPTY;
      case (state)
         ST_LOW:
         begin
            if (line_level && duration >= ticks_of(rising_detect_time))
            begin
               ev_valid   = 1'b1;
               ev_code    = `HPE_ENTRY_RISING;
               next_state = ST_HIGH;
            end
         end
         ST_HIGH:
         begin
            if (!line_level && duration >= ticks_of(falling_detect_time))
            begin
               ev_valid   = 1'b1;
               ev_code    = `HPE_ENTRY_FALLING;
               next_state = ST_LOW;
            end
            else if (level_change && sync3
                     && duration >= ticks_of({8'h00, short_pulse_min_time})
                     && duration <= ticks_of({8'h00, short_pulse_max_time}))
            begin
               ev_valid = 1'b1;
               ev_code  = `HPE_ENTRY_PULSE;
            end
         end
         default:
            next_state = ST_LOW;
      endcase
      if (!input_active)
      begin
         ev_valid   = 1'b0;
         next_state = ST_LOW;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= ST_LOW;
      else
         state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event queue
   always @*
   begin
      next_queue = hot_plug_event_queue;
      for (i = 0; i < 4; i = i + 1)
         if (wr_low && hit(paddr, `HPE_IDX_EVENT_QUEUE)
             && pwdata[2*i +: 2] == `HPE_ENTRY_FREE)
            next_queue[2*i +: 2] = `HPE_ENTRY_EMPTY;
      if (store_event)
         next_queue[{wr_ptr, 1'b0} +: 2] = ev_code;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hot_plug_event_queue <= `HPE_RST_QUEUE;
         wr_ptr               <= 2'h0;
      end
      else if (!input_active)
      begin
         hot_plug_event_queue <= `HPE_RST_QUEUE;
         wr_ptr               <= 2'h0;
      end
      else
      begin
         hot_plug_event_queue <= next_queue;
         if (store_event)
            wr_ptr <= wr_ptr + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status, enable and setting registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         line_control              <= `HPE_RST_CONTROL;
         hot_plug_event_status     <= `HPE_RST_STATUS;
         hot_plug_event_irq_enable <= `HPE_RST_IRQ_ENABLE;
         short_pulse_min_time      <= `HPE_RST_TIME8;
         short_pulse_max_time      <= `HPE_RST_TIME8;
         rising_detect_time        <= `HPE_RST_TIME16;
         falling_detect_time       <= `HPE_RST_TIME16;
      end
      else
      begin
         if (wr_low && hit(paddr, `HPE_IDX_LINE_CONTROL))
            line_control <= pwdata[1:0];
         if (wr_low && hit(paddr, `HPE_IDX_IRQ_ENABLE))
            hot_plug_event_irq_enable <= pwdata[3:0];
         if (wr_low && hit(paddr, `HPE_IDX_PULSE_MIN))
            short_pulse_min_time <= pwdata[7:0];
         if (wr_low && hit(paddr, `HPE_IDX_PULSE_MAX))
            short_pulse_max_time <= pwdata[7:0];
         if (hit(paddr, `HPE_IDX_RISING_TIME))
         begin
            if (wr_low)
               rising_detect_time[7:0] <= pwdata[7:0];
            if (wr_high)
               rising_detect_time[15:8] <= pwdata[15:8];
         end
         if (hit(paddr, `HPE_IDX_FALLING_TIME))
         begin
            if (wr_low)
               falling_detect_time[7:0] <= pwdata[7:0];
            if (wr_high)
               falling_detect_time[15:8] <= pwdata[15:8];
         end

         if (!line_enabled)
            hot_plug_event_status <= `HPE_RST_STATUS;
         else
         begin
            // Clear first, set afterwards so a coincident event wins
            if (wr_low && hit(paddr, `HPE_IDX_EVENT_STATUS))
               hot_plug_event_status[2:0] <= hot_plug_event_status[2:0]
                                             & ~pwdata[2:0];
            if (queue_read)
               hot_plug_event_status[`HPE_STS_NOT_EMPTY_BIT] <= 1'b0;
            if (store_event)
               hot_plug_event_status[`HPE_STS_NOT_EMPTY_BIT] <= 1'b1;
            if (ev_valid && ev_code == `HPE_ENTRY_RISING)
               hot_plug_event_status[`HPE_STS_RISING_BIT] <= 1'b1;
            if (ev_valid && ev_code == `HPE_ENTRY_FALLING)
               hot_plug_event_status[`HPE_STS_FALLING_BIT] <= 1'b1;
            if ((ev_valid && ev_code == `HPE_ENTRY_PULSE)
                || (line_output && pulse_gen_done))
               hot_plug_event_status[`HPE_STS_PULSE_BIT] <= 1'b1;
         end
      end
   end

   assign line_summary_interrupt =
      |(hot_plug_event_status & hot_plug_event_irq_enable);

   ////////////////////////////////////////////////////////////////////////////////
   // APB read data, captured in the setup cycle
   always @*
   begin
      next_rdata = 32'h00000000;
      next_err   = 1'b0;
      if (hit(paddr, `HPE_IDX_LINE_CONTROL))
         next_rdata = {24'h000000, line_level & line_enabled, 5'h00, line_control};
      else if (hit(paddr, `HPE_IDX_EVENT_STATUS))
         next_rdata = {28'h0000000, hot_plug_event_status};
      else if (hit(paddr, `HPE_IDX_IRQ_ENABLE))
         next_rdata = {28'h0000000, hot_plug_event_irq_enable};
      else if (hit(paddr, `HPE_IDX_EVENT_QUEUE))
         next_rdata = {24'h000000, input_active ? hot_plug_event_queue : 8'h00};
      else if (hit(paddr, `HPE_IDX_PULSE_MIN))
         next_rdata = {24'h000000, short_pulse_min_time};
      else if (hit(paddr, `HPE_IDX_PULSE_MAX))
         next_rdata = {24'h000000, short_pulse_max_time};
      else if (hit(paddr, `HPE_IDX_RISING_TIME))
         next_rdata = {16'h0000, rising_detect_time};
      else if (hit(paddr, `HPE_IDX_FALLING_TIME))
         next_rdata = {16'h0000, falling_detect_time};
      else
         next_err = 1'b1;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata  <= pwrite ? 32'h00000000 : next_rdata;
         pslverr <= next_err;
      end
   end

endmodule // hpe_detector

/* hpe_defs.vh */
`ifndef HPE_DEFS_VH
`define HPE_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the byte address is four times the index
`define HPE_IDX_LINE_CONTROL   12'hC00
`define HPE_IDX_EVENT_STATUS   12'hC01
`define HPE_IDX_IRQ_ENABLE     12'hC02
`define HPE_IDX_EVENT_QUEUE    12'hC03
`define HPE_IDX_PULSE_MIN      12'hC04
`define HPE_IDX_PULSE_MAX      12'hC05
`define HPE_IDX_RISING_TIME    12'hC06
`define HPE_IDX_FALLING_TIME   12'hC08

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define HPE_CTL_ENABLE_BIT     0
`define HPE_CTL_OUTPUT_BIT     1
`define HPE_STS_PULSE_BIT      0
`define HPE_STS_FALLING_BIT    1
`define HPE_STS_RISING_BIT     2
`define HPE_STS_NOT_EMPTY_BIT  3

////////////////////////////////////////////////////////////////////////////////
// Queue entry codes
`define HPE_ENTRY_EMPTY        2'h0
`define HPE_ENTRY_RISING       2'h1
`define HPE_ENTRY_FALLING      2'h2
`define HPE_ENTRY_PULSE        2'h3
`define HPE_ENTRY_FREE         2'h1

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define HPE_RST_CONTROL        2'h0
`define HPE_RST_STATUS         4'h0
`define HPE_RST_IRQ_ENABLE     4'h0
`define HPE_RST_QUEUE          8'h00
`define HPE_RST_TIME8          8'h00
`define HPE_RST_TIME16         16'h0000

////////////////////////////////////////////////////////////////////////////////
// Timing
`define HPE_CLK_NS             20
`define HPE_TICK_US            50
`define HPE_OFFSET_US          100
`define HPE_TICK_CYC           ((`HPE_TICK_US * 1000) / `HPE_CLK_NS)
`define HPE_OFFSET_TICKS       (`HPE_OFFSET_US / `HPE_TICK_US)

`endif

/* hpe_line_model.sv */
`timescale 1ns/1ps
module hpe_line_model
(
   input  wire pclk,
   output reg  hot_plug_line
);

initial hot_plug_line = 1'b1;

// Line level is changed just after an edge and held for n edges
task drive(input logic lvl, input integer n);
   begin
      hot_plug_line <= lvl;
      repeat (n) @(posedge pclk);
   end
endtask

endmodule // hpe_line_model

/* hpe_detector_asserts.sv */
`timescale 1ns/1ps
`include "hpe_defs.vh"
module hpe_detector_checker
(
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [15:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire [31:0] prdata,
   input wire        hot_plug_line,
   input wire        pulse_gen_done,
   input wire        line_summary_interrupt
);

localparam [15:0] a_ctl = {2'h0, `HPE_IDX_LINE_CONTROL, 2'h0};
localparam [15:0] a_sts = {2'h0, `HPE_IDX_EVENT_STATUS, 2'h0};
localparam [15:0] a_en  = {2'h0, `HPE_IDX_IRQ_ENABLE, 2'h0};
localparam [15:0] a_que = {2'h0, `HPE_IDX_EVENT_QUEUE, 2'h0};
localparam [15:0] two_ticks = 2 * `HPE_TICK_CYC;

wire        wr = psel && penable && pwrite && pstrb[0];
wire        rd = psel && penable && !pwrite;
reg  [1:0]  ctl_sh;
reg  [3:0]  en_sh;
reg  [15:0] hi_cnt;
reg  [15:0] lo_cnt;
reg  [15:0] last_lo;

////////////////////////////////////////////////////////////////////////////////
// Shadows of control and enable, and line period counters
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ctl_sh  <= 2'h0;
      en_sh   <= 4'h0;
      hi_cnt  <= 16'h0000;
      lo_cnt  <= 16'h0000;
      last_lo <= 16'h0000;
   end
   else
   begin
      if (wr && paddr == a_ctl)
         ctl_sh <= pwdata[1:0];
      if (wr && paddr == a_en)
         en_sh <= pwdata[3:0];
      hi_cnt <= hot_plug_line ? hi_cnt + {15'h0000, ~&hi_cnt} : 16'h0000;
      lo_cnt <= hot_plug_line ? 16'h0000 : lo_cnt + {15'h0000, ~&lo_cnt};
      if (hot_plug_line && lo_cnt != 16'h0000)
         last_lo <= lo_cnt;
   end
end

default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);

////////////////////////////////////////////////////////////////////////////////
// Properties
property p_en_rsv;
   rd && paddr == a_en |-> prdata[31:4] == 28'h0000000;
endproperty
a_en_rsv: assert property (p_en_rsv) else $error("Enable upper bits nonzero");

property p_sts_off;
   rd && paddr == a_sts && !ctl_sh[0] && !$past(ctl_sh[0], 2) |-> prdata == 32'h0;
endproperty
a_sts_off: assert property (p_sts_off) else $error("Status nonzero while off");

property p_que_off;
   rd && paddr == a_que && ctl_sh != 2'h1 && $past(ctl_sh, 2) != 2'h1 |-> prdata == 32'h0;
endproperty
a_que_off: assert property (p_que_off) else $error("Queue nonzero while off");

property p_irq_mask;
   en_sh == 4'h0 || (!ctl_sh[0] && !$past(ctl_sh[0])) |-> !line_summary_interrupt;
endproperty
a_irq_mask: assert property (p_irq_mask) else $error("Interrupt without cause");

property p_gen_done;
   ctl_sh == 2'h3 && $past(ctl_sh) == 2'h3 && en_sh[0] && pulse_gen_done
      |=> line_summary_interrupt;
endproperty
a_gen_done: assert property (p_gen_done) else $error("Generation done lost");

property p_rise_time;
   en_sh == 4'h4 && $stable(en_sh) && $rose(line_summary_interrupt) |-> hi_cnt >= two_ticks;
endproperty
a_rise_time: assert property (p_rise_time) else $error("Rising event too early");

property p_fall_time;
   en_sh == 4'h2 && $stable(en_sh) && $rose(line_summary_interrupt) |-> lo_cnt >= two_ticks;
endproperty
a_fall_time: assert property (p_fall_time) else $error("Falling event too early");

property p_pulse_min;
   en_sh == 4'h1 && $stable(en_sh) && ctl_sh == 2'h1 && $rose(line_summary_interrupt)
      |-> last_lo >= two_ticks;
endproperty
a_pulse_min: assert property (p_pulse_min) else $error("Short pulse too short");

c_rise: cover property (en_sh == 4'h4 && $rose(line_summary_interrupt));
c_que: cover property (rd && paddr == a_que && prdata != 32'h0);
c_gen: cover property (pulse_gen_done && ctl_sh == 2'h3);

endmodule // hpe_detector_checker

bind hpe_detector hpe_detector_checker hpe_detector_checker_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .hot_plug_line(hot_plug_line), .pulse_gen_done(pulse_gen_done),
   .line_summary_interrupt(line_summary_interrupt)
);

/* hot_plug_event_detector_bench.sv */
`timescale 1ns/1ps
`include "hpe_defs.vh"
module hot_plug_event_detector_bench;

localparam [11:0] ix_ctl  = `HPE_IDX_LINE_CONTROL;
localparam [11:0] ix_sts  = `HPE_IDX_EVENT_STATUS;
localparam [11:0] ix_en   = `HPE_IDX_IRQ_ENABLE;
localparam [11:0] ix_que  = `HPE_IDX_EVENT_QUEUE;
localparam [11:0] ix_max  = `HPE_IDX_PULSE_MAX;
localparam [11:0] ix_min  = `HPE_IDX_PULSE_MIN;
localparam [11:0] ix_rise = `HPE_IDX_RISING_TIME;
localparam [11:0] ix_fall = `HPE_IDX_FALLING_TIME;
localparam integer tk     = `HPE_TICK_CYC;

reg         pclk;
reg         presetn;
reg         psel;
reg         penable;
reg         pwrite;
reg  [15:0] paddr;
reg  [31:0] pwdata;
reg         pulse_gen_done;
wire [31:0] prdata;
wire        pready;
wire        pslverr;
wire        hot_plug_line;
wire        line_summary_interrupt;
integer     bad_count;
integer     cmp_count;
integer     i;
reg  [31:0] rdv;
reg         errv;

hpe_detector hpe_detector_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .hot_plug_line(hot_plug_line), .pulse_gen_done(pulse_gen_done),
   .line_summary_interrupt(line_summary_interrupt)
);

hpe_line_model hpe_line_model_i
(
   .pclk(pclk),
   .hot_plug_line(hot_plug_line)
);

////////////////////////////////////////////////////////////////////////////////
// Tasks
task final_report;
   begin
      $display("Compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
endtask

task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   end
endtask

// One transfer, entered just after an edge; an idle edge follows
task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
   integer n;
   begin
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
         @(posedge pclk);
         n = n + 1;
      end
      if (n == 16)
      begin
         bad_count = bad_count + 1;
         final_report;
      end
      rdv  = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   end
endtask

task wr(input logic [11:0] idx, input logic [31:0] wd);
   apb(1'b1, idx, wd);
endtask

task rchk(input logic [11:0] idx, input logic [31:0] exp);
   begin
      apb(1'b0, idx, 32'h0);
      chk($sformatf("reg %h", idx), rdv, exp);
   end
endtask

task hold(input logic lvl, input integer ticks);
   hpe_line_model_i.drive(lvl, ticks * tk + 300);
endtask

task irq(input logic e);
   chk("irq", {31'h0, line_summary_interrupt}, {31'h0, e});
endtask

////////////////////////////////////////////////////////////////////////////////
// Clock and sequence
initial
begin
   pclk = 1'b0;
   forever #10 pclk = ~pclk;
end

initial
begin
   presetn = 1'b0;
   psel = 1'b0;
   penable = 1'b0;
   pwrite = 1'b0;
   paddr = 16'h0000;
   pwdata = 32'h0;
   pulse_gen_done = 1'b0;
   bad_count = 0;
   cmp_count = 0;
   repeat (20) @(posedge pclk);
   presetn <= 1'b1;
   @(posedge pclk);
   for (i = 0; i < 7; i = i + 1)
      rchk(ix_ctl + i[11:0], 32'h0);
   apb(1'b0, 12'hC0F, 32'h0);
   chk("unmapped", {31'h0, errv}, 32'h1);
   wr(ix_en, 32'hFF);
   rchk(ix_en, 32'hF);
   wr(ix_en, 32'h4);
   wr(ix_max, 32'h2);
   wr(ix_min, 32'h1);
   rchk(ix_min, 32'h1);
   wr(ix_rise, 32'hA5C3);
   rchk(ix_rise, 32'hA5C3);
   wr(ix_rise, 32'h0);
   rchk(ix_rise, 32'h0);
   wr(ix_fall, 32'h5);
   rchk(ix_fall, 32'h5);
   wr(ix_ctl, 32'h1);
   hold(1'b1, 2);
   rchk(ix_sts, 32'hC);
   irq(1'b1);
   rchk(ix_que, 32'h1);
   rchk(ix_sts, 32'h4);
   wr(ix_sts, 32'h4);
   rchk(ix_sts, 32'h0);
   irq(1'b0);
   // Short pulse, then too short, then too long with a long high after
   wr(ix_en, 32'h1);
   hold(1'b0, 3);
   hold(1'b1, 0);
   rchk(ix_sts, 32'h9);
   rchk(ix_que, 32'hD);
   wr(ix_sts, 32'hF);
   hold(1'b0, 1);
   hold(1'b1, 0);
   hold(1'b0, 5);
   hold(1'b1, 2);
   rchk(ix_sts, 32'h0);
   // Falling, filling the queue, overflow, free and wrap
   wr(ix_en, 32'h2);
   hold(1'b0, 7);
   rchk(ix_sts, 32'hA);
   hold(1'b1, 2);
   rchk(ix_que, 32'h6D);
   hold(1'b0, 7);
   rchk(ix_que, 32'h6D);
   wr(ix_que, 32'h1);
   rchk(ix_que, 32'h6C);
   hold(1'b1, 2);
   rchk(ix_que, 32'h6D);
   wr(ix_en, 32'h0);
   irq(1'b0);
   // Disable, then output mode
   wr(ix_ctl, 32'h0);
   rchk(ix_sts, 32'h0);
   rchk(ix_que, 32'h0);
   wr(ix_ctl, 32'h3);
   wr(ix_en, 32'h1);
   pulse_gen_done <= 1'b1;
   @(posedge pclk);
   pulse_gen_done <= 1'b0;
   @(posedge pclk);
   rchk(ix_sts, 32'h1);
   irq(1'b1);
   rchk(ix_que, 32'h0);
   wr(ix_ctl, 32'h0);
   rchk(ix_sts, 32'h0);
   final_report;
end

endmodule // hot_plug_event_detector_bench
